/* verilog/mbsea_slave.sv */
// modbus slave request handler with event-list access
// assumes decoded requests and an event log source on the same clock
`timescale 1ns/1ps

module mbsea_slave #(
  parameter logic [15:0] MODEL_CODE = mbsea_pkg::MODEL_DEF,
  parameter logic [15:0] VERSION_NUM = mbsea_pkg::VERSION_DEF,
  parameter logic [15:0] ISSUE_NUM = mbsea_pkg::ISSUE_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_data,
  output logic resp_valid,
  output logic [7:0] resp_func,
  output logic [15:0] resp_data,
  output logic resp_echo,
  output logic comm_restart,
  output logic hold_readings,
  input wire logic [7:0] log_count,
  output logic log_req,
  output logic [7:0] log_idx,
  input wire logic log_word_valid,
  input wire logic [15:0] log_word,
  input wire logic log_last,
  output logic log_ack,
  output logic [7:0] log_ack_idx
);

  // ---------------------------------------------------------------
  // version and issue identity words, zero forced up to one
  // ---------------------------------------------------------------
  localparam logic [15:0] VER_POS = (VERSION_NUM == 16'h0000) ? mbsea_pkg::POS_FLOOR : VERSION_NUM;
  localparam logic [15:0] ISS_POS = (ISSUE_NUM == 16'h0000) ? mbsea_pkg::POS_FLOOR : ISSUE_NUM;

  typedef struct packed {
    mbsea_pkg::mbsea_state_t st;
    logic hold;
    logic listen;
    logic rsp_vld;
    logic [7:0] rsp_func;
    logic [15:0] rsp_data;
    logic rsp_echo;
    logic restart;
    logic log_req;
    logic log_ack;
    logic clr;
    logic [7:0] list_len;
    logic [7:0] cur;
    logic [5:0] wr_cnt;
    logic [15:0] sv_data;
  } mbsea_ctl_t;

  mbsea_ctl_t q_ff;
  mbsea_ctl_t nxt_q;
  logic take;
  logic [15:0] text_off;
  logic [7:0] nav_len;
  logic [7:0] nav_cur;

  mbsea_buf_if bif ();

  mbsea_text_store u_store (
    .clk(clk),
    .sys_rst(sys_rst),
    .bif(bif)
  );

  // ---------------------------------------------------------------
  // store hookup
  // ---------------------------------------------------------------
  assign text_off = req_addr - mbsea_pkg::A_TEXT_FIRST;
  assign bif.ce = ce;
  assign bif.clr = q_ff.clr;
  assign bif.wr = (q_ff.st == mbsea_pkg::MBSEA_FETCH) && log_word_valid;
  assign bif.wr_idx = q_ff.wr_cnt;
  assign bif.wr_data = log_word;
  assign bif.rd_idx = text_off[5:0];

  // request is taken only while idle and enabled
  assign take = ce && req_valid && (q_ff.st == mbsea_pkg::MBSEA_IDLE);
  assign req_ready = (q_ff.st == mbsea_pkg::MBSEA_IDLE);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_q = q_ff;
    nxt_q.rsp_vld = 1'b0;
    nxt_q.restart = 1'b0;
    nxt_q.log_req = 1'b0;
    nxt_q.log_ack = 1'b0;
    nxt_q.clr = 1'b0;
    nav_len = q_ff.list_len;
    nav_cur = q_ff.cur;
    case (q_ff.st)
      mbsea_pkg::MBSEA_IDLE:
      begin
        if (take && q_ff.listen)
        begin
          // silent; only restart wakes the port
          if ((req_func == mbsea_pkg::FC_DIAG) && (req_addr == mbsea_pkg::SUB_RESTART))
          begin
            nxt_q.listen = 1'b0;
            nxt_q.restart = 1'b1;
          end
        end
        else if (take)
        begin
          nxt_q.rsp_vld = 1'b1;
          nxt_q.rsp_func = req_func;
          nxt_q.rsp_data = req_data;
          nxt_q.rsp_echo = 1'b0;
          case (req_func)
            mbsea_pkg::FC_RD_COILS:
            begin
              if (req_addr == mbsea_pkg::COIL_HOLD)
              begin
                nxt_q.rsp_data = {15'h0000, q_ff.hold};
              end
              else
              begin
                nxt_q.rsp_func = req_func | mbsea_pkg::FC_EXC_FLAG;
                nxt_q.rsp_data = {8'h00, mbsea_pkg::EXC_ILL_ADDR};
              end
            end
            mbsea_pkg::FC_RD_HOLD:
            begin
              if (req_addr == mbsea_pkg::A_SIZE)
              begin
                nxt_q.rsp_data = {10'h000, bif.len};
              end
              else if ((req_addr >= mbsea_pkg::A_TEXT_FIRST) && (req_addr <= mbsea_pkg::A_TEXT_LAST))
              begin
                nxt_q.rsp_data = bif.rd_data;
              end
              else
              begin
                nxt_q.rsp_func = req_func | mbsea_pkg::FC_EXC_FLAG;
                nxt_q.rsp_data = {8'h00, mbsea_pkg::EXC_ILL_ADDR};
              end
            end
            mbsea_pkg::FC_RD_INPUT:
            begin
              // no input registers at all
              nxt_q.rsp_func = req_func | mbsea_pkg::FC_EXC_FLAG;
              nxt_q.rsp_data = {8'h00, mbsea_pkg::EXC_ILL_FUNC};
            end
            mbsea_pkg::FC_WR_COIL:
            begin
              if (req_addr != mbsea_pkg::COIL_HOLD)
              begin
                nxt_q.rsp_func = req_func | mbsea_pkg::FC_EXC_FLAG;
                nxt_q.rsp_data = {8'h00, mbsea_pkg::EXC_ILL_ADDR};
              end
              else if (req_data == mbsea_pkg::COIL_ON)
              begin
                nxt_q.hold = 1'b1;
              end
              else if (req_data == mbsea_pkg::COIL_OFF)
              begin
                nxt_q.hold = 1'b0;
              end
              else
              begin
                nxt_q.rsp_func = req_func | mbsea_pkg::FC_EXC_FLAG;
                nxt_q.rsp_data = {8'h00, mbsea_pkg::EXC_ILL_VALUE};
              end
            end
            mbsea_pkg::FC_WR_REG:
            begin
              if ((req_addr != mbsea_pkg::A_REFRESH) && (req_addr != mbsea_pkg::A_ACK)
                  && (req_addr != mbsea_pkg::A_NEXT))
              begin
                nxt_q.rsp_func = req_func | mbsea_pkg::FC_EXC_FLAG;
                nxt_q.rsp_data = {8'h00, mbsea_pkg::EXC_ILL_ADDR};
              end
              else if (q_ff.hold)
              begin
                // event window frozen while readings are held
                nxt_q.rsp_func = req_func | mbsea_pkg::FC_EXC_FLAG;
                nxt_q.rsp_data = {8'h00, mbsea_pkg::EXC_BUSY};
              end
              else
              begin
                if (req_addr == mbsea_pkg::A_REFRESH)
                begin
                  nav_len = log_count;
                  nav_cur = 8'h00;
                end
                else if ((req_addr == mbsea_pkg::A_ACK) && (q_ff.cur < q_ff.list_len))
                begin
                  // log drops the entry, next one slides into place
                  nxt_q.log_ack = 1'b1;
                  nav_len = q_ff.list_len - 8'h01;
                end
                else if ((req_addr == mbsea_pkg::A_NEXT) && (q_ff.cur < q_ff.list_len))
                begin
                  nav_cur = q_ff.cur + 8'h01;
                end
                nxt_q.list_len = nav_len;
                nxt_q.cur = nav_cur;
                nxt_q.clr = 1'b1;
                nxt_q.wr_cnt = 6'h00;
                nxt_q.sv_data = req_data;
                if (nav_cur < nav_len)
                begin
                  nxt_q.log_req = 1'b1;
                  nxt_q.rsp_vld = 1'b0;
                  nxt_q.st = mbsea_pkg::MBSEA_FETCH;
                end
              end
            end
            mbsea_pkg::FC_DIAG:
            begin
              case (req_addr)
                mbsea_pkg::SUB_ECHO:
                begin
                  nxt_q.rsp_echo = 1'b1;
                end
                mbsea_pkg::SUB_RESTART:
                begin
                  nxt_q.restart = 1'b1;
                end
                mbsea_pkg::SUB_LISTEN:
                begin
                  nxt_q.rsp_vld = 1'b0;
                  nxt_q.listen = 1'b1;
                end
                default:
                begin
                  nxt_q.rsp_func = req_func | mbsea_pkg::FC_EXC_FLAG;
                  nxt_q.rsp_data = {8'h00, mbsea_pkg::EXC_ILL_FUNC};
                end
              endcase
            end
            mbsea_pkg::FC_SLAVE_ID:
            begin
              // word select rides on the address field
              case (req_addr[1:0])
                mbsea_pkg::ID_MODEL: nxt_q.rsp_data = MODEL_CODE;
                mbsea_pkg::ID_VERSION: nxt_q.rsp_data = VER_POS;
                mbsea_pkg::ID_ISSUE: nxt_q.rsp_data = ISS_POS;
                default:
                begin
                  nxt_q.rsp_func = req_func | mbsea_pkg::FC_EXC_FLAG;
                  nxt_q.rsp_data = {8'h00, mbsea_pkg::EXC_ILL_ADDR};
                end
              endcase
            end
            default:
            begin
              nxt_q.rsp_func = req_func | mbsea_pkg::FC_EXC_FLAG;
              nxt_q.rsp_data = {8'h00, mbsea_pkg::EXC_ILL_FUNC};
            end
          endcase
        end
      end
      mbsea_pkg::MBSEA_FETCH:
      begin
        // collect the current event text from the log
        if (log_word_valid && (q_ff.wr_cnt < mbsea_pkg::TEXT_WORDS))
        begin
          nxt_q.wr_cnt = q_ff.wr_cnt + 6'h01;
        end
        if (log_word_valid && log_last)
        begin
          nxt_q.st = mbsea_pkg::MBSEA_IDLE;
          nxt_q.rsp_vld = 1'b1;
          nxt_q.rsp_func = mbsea_pkg::FC_WR_REG;
          nxt_q.rsp_data = q_ff.sv_data;
        end
      end
      default:
      begin
        nxt_q.st = mbsea_pkg::MBSEA_IDLE;
      end
    endcase
  end

  // state register, frozen while ce is low
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q_ff <= '0;
    end
    else if (ce)
    begin
      q_ff <= nxt_q;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign resp_valid = q_ff.rsp_vld;
  assign resp_func = q_ff.rsp_func;
  assign resp_data = q_ff.rsp_data;
  assign resp_echo = q_ff.rsp_echo;
  assign comm_restart = q_ff.restart;
  assign hold_readings = q_ff.hold;
  assign log_req = q_ff.log_req;
  assign log_idx = q_ff.cur;
  assign log_ack = q_ff.log_ack;
  assign log_ack_idx = q_ff.cur;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_talk;
    take && !q_ff.listen;
  endsequence

  sequence s_refresh;
    s_talk ##0 (req_func == mbsea_pkg::FC_WR_REG) && (req_addr == mbsea_pkg::A_REFRESH)
      && !q_ff.hold && (log_count != 8'h00);
  endsequence

  sequence s_ack;
    s_talk ##0 (req_func == mbsea_pkg::FC_WR_REG) && (req_addr == mbsea_pkg::A_ACK)
      && !q_ff.hold && (q_ff.cur < q_ff.list_len);
  endsequence

  AST_INPUT_REJECT: assert property (s_talk ##0 (req_func == mbsea_pkg::FC_RD_INPUT) |=>
    resp_valid && (resp_func == (mbsea_pkg::FC_RD_INPUT | mbsea_pkg::FC_EXC_FLAG))
    && (resp_data[7:0] == mbsea_pkg::EXC_ILL_FUNC))
    else $error("input register read not rejected");

  AST_OTHER_COIL: assert property (s_talk ##0 (req_func == mbsea_pkg::FC_WR_COIL)
    && (req_addr != mbsea_pkg::COIL_HOLD) |=> resp_func[7] && $stable(hold_readings))
    else $error("foreign coil write not refused");

  AST_COIL_ON: assert property (s_talk ##0 (req_func == mbsea_pkg::FC_WR_COIL)
    && (req_addr == mbsea_pkg::COIL_HOLD) && (req_data == mbsea_pkg::COIL_ON) |=> hold_readings && !resp_func[7])
    else $error("hold coil did not activate");

  AST_HOLD_FROZEN: assert property (q_ff.hold && (q_ff.st == mbsea_pkg::MBSEA_IDLE) |=> $stable(bif.len))
    else $error("event window changed while held");

  AST_SIZE_READ: assert property (s_talk ##0 (req_func == mbsea_pkg::FC_RD_HOLD)
    && (req_addr == mbsea_pkg::A_SIZE) |=> resp_valid && (resp_data == {10'h000, $past(bif.len)}))
    else $error("size read mismatch");

  AST_REFRESH: assert property (s_refresh |=> log_req && (log_idx == 8'h00) && !resp_valid)
    else $error("refresh did not fetch newest event");

  AST_ACK: assert property (s_ack |=> log_ack && (log_ack_idx == $past(q_ff.cur))
    && (log_req == (log_idx < q_ff.list_len)))
    else $error("acknowledge not issued to log");

  AST_LISTEN_SILENT: assert property (q_ff.listen |=> !resp_valid)
    else $error("reply sent in listen-only mode");

  AST_ECHO: assert property (s_talk ##0 (req_func == mbsea_pkg::FC_DIAG) && (req_addr == mbsea_pkg::SUB_ECHO)
    |=> resp_valid && resp_echo && (resp_data == $past(req_data)))
    else $error("echo reply wrong");

  AST_FETCH_END: assert property ((q_ff.st == mbsea_pkg::MBSEA_FETCH) && ce && log_word_valid && log_last
    |=> resp_valid && req_ready)
    else $error("fetch did not finish with reply");

endmodule

/* verilog/mbsea_pkg.sv */
// shared constants and types of the modbus slave event-access block
// assumes a framing layer that delivers decoded requests on the same clock
package mbsea_pkg;

  // ---------------------------------------------------------------
  // function codes
  // ---------------------------------------------------------------
  localparam logic [7:0] FC_RD_COILS = 8'h01;
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_RD_INPUT = 8'h04;
  localparam logic [7:0] FC_WR_COIL = 8'h05;
  localparam logic [7:0] FC_WR_REG = 8'h06;
  localparam logic [7:0] FC_DIAG = 8'h08;
  localparam logic [7:0] FC_SLAVE_ID = 8'h11;
  localparam logic [7:0] FC_EXC_FLAG = 8'h80;

  // ---------------------------------------------------------------
  // exception codes
  // ---------------------------------------------------------------
  localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
  localparam logic [7:0] EXC_ILL_VALUE = 8'h03;
  localparam logic [7:0] EXC_BUSY = 8'h06;

  // ---------------------------------------------------------------
  // diagnostic subfunctions
  // ---------------------------------------------------------------
  localparam logic [15:0] SUB_ECHO = 16'h0000;
  localparam logic [15:0] SUB_RESTART = 16'h0001;
  localparam logic [15:0] SUB_LISTEN = 16'h0004;

  // ---------------------------------------------------------------
  // coil and register map
  // ---------------------------------------------------------------
  localparam logic [15:0] COIL_HOLD = 16'h0001;
  localparam logic [15:0] COIL_ON = 16'hff00;
  localparam logic [15:0] COIL_OFF = 16'h0000;
  localparam logic [15:0] A_REFRESH = 16'h9f41;
  localparam logic [15:0] A_ACK = 16'h9f42;
  localparam logic [15:0] A_NEXT = 16'h9f43;
  localparam logic [15:0] A_SIZE = 16'h9f44;
  localparam logic [15:0] A_TEXT_FIRST = 16'h9f46;
  localparam logic [15:0] A_TEXT_LAST = 16'h9f80;
  localparam logic [5:0] TEXT_WORDS = 6'h3b;

  // ---------------------------------------------------------------
  // slave-id payload word select and defaults
  // ---------------------------------------------------------------
  localparam logic [1:0] ID_MODEL = 2'h0;
  localparam logic [1:0] ID_VERSION = 2'h1;
  localparam logic [1:0] ID_ISSUE = 2'h2;
  localparam logic [15:0] MODEL_DEF = 16'h5a3c; // arbitrary value
  localparam logic [15:0] VERSION_DEF = 16'h0001;
  localparam logic [15:0] ISSUE_DEF = 16'h0001;
  localparam logic [15:0] POS_FLOOR = 16'h0001;

  // controller states, gray along idle -> fetch -> idle
  typedef enum logic [1:0] {
    MBSEA_IDLE = 2'h0,
    MBSEA_FETCH = 2'h1
  } mbsea_state_t;

endpackage

/* verilog/mbsea_buf_if.sv */
// carrier between request controller and event text store
// assumes both ends share clk and the clock enable carried here
`timescale 1ns/1ps
interface mbsea_buf_if;
  logic ce;
  logic clr;
  logic wr;
  logic [5:0] wr_idx;
  logic [15:0] wr_data;
  logic [5:0] rd_idx;
  logic [15:0] rd_data;
  logic [5:0] len;

  modport ctrl (output ce, output clr, output wr, output wr_idx, output wr_data, output rd_idx,
                input rd_data, input len);
  modport store (input ce, input clr, input wr, input wr_idx, input wr_data, input rd_idx,
                 output rd_data, output len);
endinterface

/* verilog/mbsea_text_store.sv */
// event text store: one current event, two ascii characters a word
// assumes words arrive in order from index zero after a clear
`timescale 1ns/1ps
module mbsea_text_store (
  input wire logic clk,
  input wire logic sys_rst,
  mbsea_buf_if.store bif
);

  typedef struct packed {
    logic [58:0][15:0] mem;
    logic [5:0] len;
  } mbsea_store_t;

  mbsea_store_t q_ff;
  mbsea_store_t nxt_q;

  // ---------------------------------------------------------------
  // next state: clear, then fill word by word
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_q = q_ff;
    if (bif.clr)
    begin
      nxt_q.len = 6'h00;
    end
    // a word arriving with the clear still lands, so a fast log loses nothing
    if (bif.wr && (bif.wr_idx < mbsea_pkg::TEXT_WORDS))
    begin
      nxt_q.mem[bif.wr_idx] = bif.wr_data;
      nxt_q.len = bif.wr_idx + 6'h01; // length follows last word
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q_ff <= '0;
    end
    else if (bif.ce)
    begin
      q_ff <= nxt_q;
    end
  end

  // ---------------------------------------------------------------
  // read side: words past the message read as zero
  // ---------------------------------------------------------------
  always_comb
  begin
    bif.rd_data = 16'h0000;
    if (bif.rd_idx < q_ff.len)
    begin
      bif.rd_data = q_ff.mem[bif.rd_idx];
    end
  end

  assign bif.len = q_ff.len;

endmodule

/* bench/mbsea_log_model.sv */
// event log partner: a short list of numbered events, newest first
// assumes one fetch at a time from the slave, same clock and enable
`timescale 1ns/1ps
module mbsea_log_model (
  input wire logic clk,
  input wire logic ce,
  input wire logic log_req,
  input wire logic [7:0] log_idx,
  input wire logic log_ack,
  input wire logic [7:0] log_ack_idx,
  output logic [7:0] log_count,
  output logic log_word_valid,
  output logic [15:0] log_word,
  output logic log_last
);
  int ev[$] = '{0, 1, 2};
  int id = 0;
  int n = 0;
  int len = 0;
  logic busy = 1'b0;
  logic gap = 1'b0;

  initial
  begin
    log_count = 8'h03;
    log_word_valid = 1'b0;
    log_word = 16'h0000;
    log_last = 1'b0;
  end

  // event k holds 3k+2 words, word i is {'A'+k, '0'+i}; words every other cycle
  always @(posedge clk)
  begin
    if (ce)
    begin
      if (log_ack && log_ack_idx < ev.size())
        ev.delete(log_ack_idx);
      if (log_req)
      begin
        busy = 1'b1;
        n = 0;
        id = (log_idx < ev.size()) ? ev[log_idx] : -1;
        len = (id < 0) ? 1 : 3 * id + 2;
      end
      gap = ~gap;
      log_count <= 8'(ev.size());
      if (busy && !gap)
      begin
        n++;
        log_word_valid <= 1'b1;
        log_word <= (id < 0) ? 16'h0000 : {8'(8'h41 + id), 8'(8'h2f + n)};
        log_last <= (n == len);
        busy = (n != len);
      end
      else
      begin
        // released word line flips to the inverse each cycle, so past one idle cycle it shows the last value every second cycle
        log_word_valid <= 1'b0;
        log_word <= ~log_word;
        log_last <= 1'b0;
      end
    end
  end
endmodule

/* bench/tb_modbus_slave_event_access.sv */
// self-checking bench for the slave: requests in, replies compared
// assumes the event log partner model beside the design
`timescale 1ns/1ps
module tb_modbus_slave_event_access;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic req_valid = 1'b0;
  logic [7:0] req_func = 8'h00;
  logic [15:0] req_addr = 16'h0000;
  logic [15:0] req_data = 16'h0000;
  logic req_ready, resp_valid, resp_echo, comm_restart, hold_readings;
  logic log_req, log_ack, log_word_valid, log_last;
  logic [7:0] resp_func, log_count, log_idx, log_ack_idx;
  logic [15:0] resp_data, log_word;
  logic got;
  logic [7:0] rf;
  logic [15:0] rd;
  int fail_count = 0;
  int check_count = 0;
  int pulses = 0;

  // ---------------------------------------------------------------
  // clock, design and partner
  // ---------------------------------------------------------------
  always #4 clk = ~clk;

  mbsea_slave #(.MODEL_CODE(16'h6b2d), .VERSION_NUM(16'h0003), .ISSUE_NUM(16'h0000)) DUT (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .req_valid(req_valid), .req_ready(req_ready),
    .req_func(req_func), .req_addr(req_addr), .req_data(req_data), .resp_valid(resp_valid),
    .resp_func(resp_func), .resp_data(resp_data), .resp_echo(resp_echo), .comm_restart(comm_restart),
    .hold_readings(hold_readings), .log_count(log_count), .log_req(log_req), .log_idx(log_idx),
    .log_word_valid(log_word_valid), .log_word(log_word), .log_last(log_last), .log_ack(log_ack),
    .log_ack_idx(log_ack_idx));

  mbsea_log_model log_model (
    .clk(clk), .ce(ce), .log_req(log_req), .log_idx(log_idx), .log_ack(log_ack),
    .log_ack_idx(log_ack_idx), .log_count(log_count), .log_word_valid(log_word_valid),
    .log_word(log_word), .log_last(log_last));

  // restart pulse counter
  always @(posedge clk)
    if (comm_restart === 1'b1)
      pulses <= pulses + 1;

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic conclude;
    if (fail_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one request held until taken, then a bounded wait for the reply pulse
  task automatic rq(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
    int i;
    @(negedge clk);
    req_valid = 1'b1;
    req_func = f;
    req_addr = a;
    req_data = d;
    i = 0;
    while (req_ready !== 1'b1 && i < 100)
    begin
      @(negedge clk);
      i++;
    end
    if (i == 100)
    begin
      fail_count++;
      conclude();
    end
    @(negedge clk);
    req_valid = 1'b0;
    got = 1'b0;
    i = 0;
    while (got == 1'b0 && i < 60)
    begin
      if (resp_valid === 1'b1)
      begin
        got = 1'b1;
        rf = resp_func;
        rd = resp_data;
      end
      else
      begin
        @(negedge clk);
        i++;
      end
    end
  endtask

  task automatic op(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
                    input logic [7:0] ef, input logic [15:0] ed);
    rq(f, a, d);
    chk("reply", {15'h0000, got}, 16'h0001);
    chk("func", {8'h00, rf}, {8'h00, ef});
    chk("data", rd, ed);
  endtask

  task automatic quiet(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
    rq(f, a, d);
    chk("silent", {15'h0000, got}, 16'h0000);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    op(8'h04, 16'h0000, 16'h0000, 8'h84, 16'h0001);
    op(8'h06, 16'h9f41, 16'h0000, 8'h06, 16'h0000);
    op(8'h03, 16'h9f44, 16'h0000, 8'h03, 16'h0002);
    op(8'h03, 16'h9f46, 16'h0000, 8'h03, 16'h4130);
    op(8'h03, 16'h9f48, 16'h0000, 8'h03, 16'h0000);
    op(8'h03, 16'h9f80, 16'h0000, 8'h03, 16'h0000);
    op(8'h06, 16'h9f43, 16'h0000, 8'h06, 16'h0000);
    op(8'h03, 16'h9f44, 16'h0000, 8'h03, 16'h0005);
    op(8'h03, 16'h9f4a, 16'h0000, 8'h03, 16'h4234);
    op(8'h06, 16'h9f42, 16'h0000, 8'h06, 16'h0000);
    op(8'h03, 16'h9f44, 16'h0000, 8'h03, 16'h0008);
    op(8'h06, 16'h9f41, 16'h0000, 8'h06, 16'h0000);
    op(8'h03, 16'h9f44, 16'h0000, 8'h03, 16'h0002);
    op(8'h06, 16'h9f43, 16'h0000, 8'h06, 16'h0000);
    op(8'h03, 16'h9f44, 16'h0000, 8'h03, 16'h0008);
    op(8'h05, 16'h0001, 16'hff00, 8'h05, 16'hff00);
    chk("hold", {15'h0000, hold_readings}, 16'h0001);
    op(8'h06, 16'h9f42, 16'h0000, 8'h86, 16'h0006);
    op(8'h03, 16'h9f44, 16'h0000, 8'h03, 16'h0008);
    op(8'h05, 16'h0001, 16'h0000, 8'h05, 16'h0000);
    chk("hold", {15'h0000, hold_readings}, 16'h0000);
    op(8'h05, 16'h0002, 16'hff00, 8'h85, 16'h0002);
    chk("hold", {15'h0000, hold_readings}, 16'h0000);
    op(8'h05, 16'h0001, 16'h1234, 8'h85, 16'h0003);
    op(8'h08, 16'h0000, 16'ha5c3, 8'h08, 16'ha5c3);
    chk("echo", {15'h0000, resp_echo}, 16'h0001);
    op(8'h08, 16'h0001, 16'h0055, 8'h08, 16'h0055);
    quiet(8'h08, 16'h0004, 16'h0000);
    chk("restart", 16'(pulses), 16'h0001);
    quiet(8'h04, 16'h0000, 16'h0000);
    quiet(8'h08, 16'h0001, 16'h0000);
    chk("restart", 16'(pulses), 16'h0002);
    op(8'h04, 16'h0000, 16'h0000, 8'h84, 16'h0001);
    op(8'h11, 16'h0000, 16'h0000, 8'h11, 16'h6b2d);
    op(8'h11, 16'h0001, 16'h0000, 8'h11, 16'h0003);
    op(8'h11, 16'h0002, 16'h0000, 8'h11, 16'h0001);
    op(8'h11, 16'h0003, 16'h0000, 8'h91, 16'h0002);
    conclude();
  end
endmodule
